//--- hdl/pwr_ctrl_consts.svh
`ifndef PWR_CTRL_CONSTS_SVH
`define PWR_CTRL_CONSTS_SVH
`define PIN_CTRL_ADDR 6'h03
`define PIN_CTRL_RESET 16'h0000
`define PIN_CTRL_WMASK 16'h07FF
`define PIN_EN_LSB 0
`define PIN_VAL_LSB 4
`define INT_SEL_LSB 8
`define SYNC_CLR_BIT 10
`define INT_SEL_SECOND_PIN 2'h1
`define MODE_CONT 4'h0
`define MODE_STANDBY 4'h2
`define MODE_PDOWN 4'h3
`define MODE_IDLE 4'h4
`define CHAN0_RESET 16'h8001
`define CFG0_RESET 16'h0000
`define FILT0_RATE_RESET 11'h030
`define FILT0_TYPE_SINC3 3'h0
`define DIAG_RESET 24'h000040
`define CTRL_RESET 16'h0000
`define SOFT_RESET_ONES 7'h40
`endif

//--- hdl/pwr_ctrl_pkg.sv
package pwr_ctrl_pkg;
	typedef enum logic [1:0] {pm_active, pm_standby, pm_idle, pm_pdown} pm_state_type;
	typedef logic [3:0] mode_code_type;
	typedef logic [2:0] gain_code_type;
endpackage

//--- hdl/gain_select.sv
`timescale 1ns/1ps
`default_nettype none
module gain_select (
	// setup fields
	input wire logic [2:0] i_gain_code,
	input wire logic i_bypass,
	// applied gain
	output logic [7:0] o_gain
);
	// bypass makes the gain field irrelevant
	always_comb begin
		if (i_bypass) begin
			o_gain = 8'h01;
		end else begin
			o_gain = 8'(8'h01 << i_gain_code);
		end
	end
endmodule // gain_select
`default_nettype wire

//--- hdl/soft_reset_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_ctrl_consts.svh"
module soft_reset_detect (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// serial input sampled on bit strobe
	input wire logic i_bit_valid,
	input wire logic i_bit,
	// full reset request, one cycle
	output logic o_soft_reset
);
	typedef struct packed {
		logic [6:0] ones;
		logic fire;
	} srd_state_type;
	srd_state_type st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		st_next.fire = 1'b0;
		if (i_bit_valid) begin
			if (!i_bit) begin
				st_next.ones = 7'h00;
			end else if (st_reg.ones == `SOFT_RESET_ONES - 7'h01) begin
				st_next.ones = 7'h00;
				st_next.fire = 1'b1;
			end else begin
				st_next.ones = st_reg.ones + 7'h01;
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign o_soft_reset = st_reg.fire;
	a_ones_fire: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.fire |-> $past(st_reg.ones) == 7'h3F && $past(i_bit_valid) && $past(i_bit))
		else $error("soft reset without 64 ones");
endmodule // soft_reset_detect
`default_nettype wire

//--- hdl/pwr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_ctrl_consts.svh"
module pwr_ctrl
	import pwr_ctrl_pkg::*;
#(
	parameter int NUM_CH = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// supply monitors, asynchronous
	input wire logic i_io_supply_ok,
	input wire logic i_dig_ldo_ok,
	input wire logic i_ana_supply_ok,
	// register access from serial interface logic
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [5:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_mode_wr,
	input wire pwr_ctrl_pkg::mode_code_type i_mode,
	input wire logic i_status_rd,
	input wire logic i_serial_bit_valid,
	input wire logic i_serial_bit,
	// sequencer and setup
	input wire logic [3:0] i_active_ch,
	input wire logic [NUM_CH-1:0] i_bridge_switch_per_channel,
	input wire logic [2:0] i_gain_code,
	input wire logic i_gain_stage_bypass,
	input wire logic i_int_level,
	// register read
	output logic [15:0] o_rdata,
	// pins, enable low while driven
	output logic [3:0] o_pin_out,
	output logic [3:0] o_pin_oe_n,
	// analog control
	output logic o_bridge_switch,
	output logic [7:0] o_gain,
	output logic o_mod_reset,
	output logic o_power_down,
	output logic o_converting,
	// status
	output logic o_not_ready_bit,
	output logic o_por_flag,
	output logic o_regs_reset,
	output logic [15:0] o_chan0_default,
	output logic [15:0] o_cfg0_default,
	output logic [10:0] o_filter_rate_field,
	output logic [2:0] o_filter_type,
	output logic [15:0] o_ctrl_default,
	output logic [23:0] o_diag_default,
	output pwr_ctrl_pkg::pm_state_type o_pm_state
);
	typedef struct packed {
		logic [1:0] io_s;
		logic [1:0] ldo_s;
		logic [15:0] pin_ctrl;
		pm_state_type pm;
		logic por_flag;
		logic [15:0] rdata;
		logic bsw;
		logic [3:0] pin_out;
	} st_type;
	st_type st_reg, st_next;
	logic soft_reset;
	logic supply_bad;
	logic full_reset;
	logic [7:0] gain_w;

	// one decode for the write, read and checking paths
	function automatic logic pin_ctrl_hit(input logic [5:0] addr);
		return addr == `PIN_CTRL_ADDR;
	endfunction

	soft_reset_detect u_srd (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_bit_valid(i_serial_bit_valid),
		.i_bit(i_serial_bit),
		.o_soft_reset(soft_reset)
	);

	gain_select u_gain (
		.i_gain_code(i_gain_code),
		.i_bypass(i_gain_stage_bypass),
		.o_gain(gain_w)
	);

	// analog supply monitor deliberately unused: its droop must not reset
	logic ana_unused;
	assign ana_unused = i_ana_supply_ok;
	assign supply_bad = !st_reg.io_s[1] || !st_reg.ldo_s[1];
	assign full_reset = supply_bad || soft_reset;

	always_comb begin
		st_next = st_reg;
		st_next.io_s = {st_reg.io_s[0], i_io_supply_ok};
		st_next.ldo_s = {st_reg.ldo_s[0], i_dig_ldo_ok};
		if (i_status_rd) begin
			st_next.por_flag = 1'b0;
		end
		if (full_reset) begin
			st_next.pin_ctrl = `PIN_CTRL_RESET;
			st_next.pm = pm_active;
			st_next.por_flag = 1'b1;
		end else if (st_reg.pm != pm_pdown) begin
			if (i_wr && pin_ctrl_hit(i_addr)) begin
				st_next.pin_ctrl = i_wdata & `PIN_CTRL_WMASK;
			end
			if (i_mode_wr) begin
				unique case (i_mode)
					`MODE_STANDBY: st_next.pm = pm_standby;
					`MODE_IDLE: st_next.pm = pm_idle;
					`MODE_PDOWN: st_next.pm = (st_reg.pm == pm_standby) ? pm_pdown : pm_active;
					default: st_next.pm = pm_active;
				endcase
			end
		end
		if (i_rd) begin
			st_next.rdata = pin_ctrl_hit(i_addr) ? st_reg.pin_ctrl : 16'h0000;
		end
		st_next.bsw = i_bridge_switch_per_channel[i_active_ch] && st_reg.pm == pm_active;
		for (int i = 0; i < 4; i++) begin
			st_next.pin_out[i] = st_reg.pin_ctrl[`PIN_VAL_LSB + i];
		end
		if (st_reg.pin_ctrl[`INT_SEL_LSB +: 2] == `INT_SEL_SECOND_PIN) begin
			st_next.pin_out[1] = i_int_level;
		end
		if (st_reg.pin_ctrl[`SYNC_CLR_BIT]) begin
			st_next.pin_out[3] = (st_reg.pm == pm_standby);
		end
		if (st_reg.pm == pm_pdown) begin
			st_next.pin_out = 4'h0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_reg <= '0;
			st_reg.por_flag <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// the standby indicator reuses the spare upper bit; no separate misc register here
	assign o_pin_out = st_reg.pin_out;
	assign o_pin_oe_n = (st_reg.pm == pm_pdown) ? 4'hF : ~st_reg.pin_ctrl[`PIN_EN_LSB +: 4];
	assign o_bridge_switch = st_reg.bsw;
	assign o_gain = gain_w;
	assign o_mod_reset = (st_reg.pm != pm_active);
	assign o_power_down = (st_reg.pm == pm_pdown);
	assign o_converting = (st_reg.pm == pm_active);
	assign o_not_ready_bit = (st_reg.pm == pm_standby);
	assign o_por_flag = st_reg.por_flag;
	assign o_regs_reset = full_reset || i_reset || (st_reg.pm == pm_pdown);
	assign o_chan0_default = `CHAN0_RESET;
	assign o_cfg0_default = `CFG0_RESET;
	assign o_filter_rate_field = `FILT0_RATE_RESET;
	assign o_filter_type = `FILT0_TYPE_SINC3;
	assign o_ctrl_default = `CTRL_RESET;
	assign o_diag_default = `DIAG_RESET;
	assign o_pm_state = st_reg.pm;
	assign o_rdata = st_reg.rdata;

	a_pdown_only_standby: assert property (@(posedge i_clk) disable iff (i_reset)
		(st_reg.pm != pm_pdown) ##1 (st_reg.pm == pm_pdown) |->
		$past(st_reg.pm) == pm_standby) else $error("power-down entered not from standby");
	a_pdown_sticky: assert property (@(posedge i_clk) disable iff (i_reset)
		(st_reg.pm == pm_pdown) && !full_reset |=> st_reg.pm == pm_pdown)
		else $error("power-down left without reset");
	a_por_set: assert property (@(posedge i_clk) disable iff (i_reset)
		full_reset |=> st_reg.por_flag) else $error("reset flag not set");
	a_por_clear: assert property (@(posedge i_clk) disable iff (i_reset)
		i_status_rd && !full_reset |=> !st_reg.por_flag) else $error("reset flag not cleared");
	a_reset_pinctrl: assert property (@(posedge i_clk) disable iff (i_reset)
		full_reset |=> st_reg.pin_ctrl == 16'h0000) else $error("pin control not reset");
	a_upper_zero: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pin_ctrl[15:11] == 5'h00) else $error("unassigned bits set");
	a_pin_enable: assert property (@(posedge i_clk) disable iff (i_reset)
		!st_reg.pin_ctrl[0] |-> o_pin_oe_n[0]) else $error("disabled pin driven");
	a_pin_value: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pin_ctrl[2] && st_reg.pm != pm_pdown |=>
		o_pin_out[2] == $past(st_reg.pin_ctrl[6])) else $error("pin value wrong");
	a_standby_flag: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm != pm_pdown && !full_reset && i_mode_wr && i_mode == `MODE_STANDBY |=>
		o_not_ready_bit) else $error("not-ready wrong");
	a_bypass_gain: assert property (@(posedge i_clk) disable iff (i_reset)
		i_gain_stage_bypass |-> o_gain == 8'h01) else $error("bypass gain not one");
	a_idle_exit: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm == pm_idle && i_mode_wr && i_mode == 4'h0 && !full_reset |=>
		st_reg.pm == pm_active) else $error("idle not left");
	c_standby: cover property (@(posedge i_clk) st_reg.pm == pm_standby);
	c_pdown: cover property (@(posedge i_clk) st_reg.pm == pm_pdown);
	c_idle: cover property (@(posedge i_clk) st_reg.pm == pm_idle);
	c_soft: cover property (@(posedge i_clk) soft_reset);
	c_refused: cover property (@(posedge i_clk) st_reg.pm == pm_active && i_mode_wr && i_mode == `MODE_PDOWN);

	// mode requests count only outside power-down and outside a full reset
	a_idle_entry: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm != pm_pdown && !full_reset && i_mode_wr && i_mode == `MODE_IDLE |=>
		st_reg.pm == pm_idle)
		else $error("idle not entered");
	a_pdown_refused: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm != pm_standby && st_reg.pm != pm_pdown && !full_reset &&
		i_mode_wr && i_mode == `MODE_PDOWN |=> st_reg.pm == pm_active)
		else $error("power-down not refused");
	a_standby_exit: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm == pm_standby && !full_reset && i_mode_wr && i_mode == `MODE_CONT |=>
		st_reg.pm == pm_active)
		else $error("standby not left");
	a_idle_to_standby: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm == pm_idle && !full_reset && i_mode_wr && i_mode == `MODE_STANDBY |=>
		st_reg.pm == pm_standby)
		else $error("idle not left for standby");
	a_idle_keeps: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm == pm_idle && !full_reset && !i_wr |=>
		$stable(st_reg.pin_ctrl))
		else $error("idle lost register content");
	a_standby_regs: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm == pm_standby && !full_reset && !i_wr |=>
		$stable(st_reg.pin_ctrl))
		else $error("standby lost register content");
	a_mod_reset: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm == pm_idle |->
		o_mod_reset && !o_converting)
		else $error("idle does not hold modulator");

	// power-down keeps every pin released until a reset brings it back
	a_pdown_frozen: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm == pm_pdown && !full_reset |=>
		$stable(st_reg.pin_ctrl))
		else $error("register changed in power-down");
	a_pdown_outputs: assert property (@(posedge i_clk) disable iff (i_reset)
		o_power_down |->
		o_pin_oe_n == 4'hF && o_regs_reset && !o_converting)
		else $error("power-down outputs wrong");

	// supply and software reset paths; the analog monitor must never reach them
	a_ana_ignored: assert property (@(posedge i_clk) disable iff (i_reset)
		!st_reg.por_flag && st_reg.io_s[1] && st_reg.ldo_s[1] && !soft_reset |=>
		!st_reg.por_flag)
		else $error("reset flag set without cause");
	a_dip_resets: assert property (@(posedge i_clk) disable iff (i_reset)
		!st_reg.io_s[1] || !st_reg.ldo_s[1] |=>
		st_reg.por_flag && st_reg.pm == pm_active && st_reg.pin_ctrl == 16'h0000)
		else $error("supply dip did not reset");
	a_soft_effect: assert property (@(posedge i_clk) disable iff (i_reset)
		soft_reset |=>
		st_reg.pin_ctrl == 16'h0000 && st_reg.pm == pm_active)
		else $error("software reset without effect");
	a_por_kept: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.por_flag && !i_status_rd |=>
		st_reg.por_flag)
		else $error("reset flag lost without read");

	// alternate pin uses override the value bit, never the enable
	a_no_stray_drive: assert property (@(posedge i_clk) disable iff (i_reset)
		(~st_reg.pin_ctrl[3:0] & ~o_pin_oe_n) == 4'h0)
		else $error("pin driven without enable");
	a_pin_value_p1: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pin_ctrl[0] && st_reg.pm != pm_pdown |=>
		o_pin_out[0] == $past(st_reg.pin_ctrl[4]))
		else $error("first pin value wrong");
	a_pin_value_p2: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pin_ctrl[1] && st_reg.pin_ctrl[`INT_SEL_LSB +: 2] != `INT_SEL_SECOND_PIN &&
		st_reg.pm != pm_pdown |=> o_pin_out[1] == $past(st_reg.pin_ctrl[5]))
		else $error("second pin value wrong");
	a_pin_value_p4: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pin_ctrl[3] && !st_reg.pin_ctrl[`SYNC_CLR_BIT] && st_reg.pm != pm_pdown |=>
		o_pin_out[3] == $past(st_reg.pin_ctrl[7]))
		else $error("fourth pin value wrong");
	a_int_route: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pin_ctrl[`INT_SEL_LSB +: 2] == `INT_SEL_SECOND_PIN && st_reg.pm != pm_pdown |=>
		o_pin_out[1] == $past(i_int_level))
		else $error("interrupt not routed");
	a_standby_pin: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pin_ctrl[`SYNC_CLR_BIT] && st_reg.pm != pm_pdown |=>
		o_pin_out[3] == ($past(st_reg.pm) == pm_standby))
		else $error("standby indicator wrong");
	a_write_mask: assert property (@(posedge i_clk) disable iff (i_reset)
		st_reg.pm != pm_pdown && !full_reset && i_wr && pin_ctrl_hit(i_addr) |=>
		st_reg.pin_ctrl == {5'h00, $past(i_wdata[10:0])})
		else $error("pin control write wrong");
	a_read_upper: assert property (@(posedge i_clk) disable iff (i_reset)
		i_rd && pin_ctrl_hit(i_addr) |=>
		o_rdata[15:11] == 5'h00)
		else $error("unassigned bits read back");

	// gain decode is combinational, so these hold in the same cycle
	a_gain_onehot: assert property (@(posedge i_clk) disable iff (i_reset)
		$onehot(o_gain))
		else $error("gain not a power of two");
	a_gain_max: assert property (@(posedge i_clk) disable iff (i_reset)
		!i_gain_stage_bypass && i_gain_code == 3'h7 |->
		o_gain == 8'h80)
		else $error("top gain wrong");
	a_gain_min: assert property (@(posedge i_clk) disable iff (i_reset)
		!i_gain_stage_bypass && i_gain_code == 3'h0 |->
		o_gain == 8'h01)
		else $error("unity gain wrong");
endmodule // pwr_ctrl
`default_nettype wire

//--- verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// clock
	input wire logic i_clk,
	// register and serial requests
	output var logic [3:0] o_req,
	output var logic [5:0] o_addr,
	output var logic [15:0] o_wdata,
	output var logic o_bit_valid,
	output var logic o_bit
);
	initial begin
		o_req = 4'h0;
		o_addr = 6'h00;
		o_wdata = 16'h0000;
		o_bit_valid = 1'b0;
		o_bit = 1'b0;
	end
	// req bits: 0 write, 1 read, 2 mode write 3 status read
	task automatic xfer(input logic [3:0] k, input logic [5:0] a, input logic [15:0] d);
		@(posedge i_clk);
		#2;
		o_req = k;
		o_addr = a;
		o_wdata = d;
		@(posedge i_clk);
		#2;
		o_req = 4'h0;
		// released data shows no stale value
		o_wdata = ~d;
	endtask
	// consecutive strobed bits; 64 ones ask for a full reset
	task automatic bits(input int n, input logic b);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			#2;
			o_bit_valid = 1'b1;
			o_bit = b;
		end
		@(posedge i_clk);
		#2;
		o_bit_valid = 1'b0;
		o_bit = ~b;
	endtask
endmodule // host_model
`default_nettype wire

//--- verif/power_mode_and_output_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_output_control_tb_top;
	import pwr_ctrl_pkg::*;
	typedef struct packed {logic [15:0] wd; logic [15:0] rd; logic [3:0] oe; logic [3:0] pv;
		logic [3:0] pm;} row_type;
	logic clk = 1'b0, rst = 1'b1, io_ok = 1'b1, ldo_ok = 1'b1, ana_ok = 1'b1, int_lvl = 1'b0;
	logic byp = 1'b0, bv, bt;
	logic [3:0] req, ch = 4'h0, pin_out, oe_n;
	logic [5:0] addr;
	logic [15:0] wdata, rdata, sw = 16'h00A5;
	logic [2:0] gcode = 3'h0;
	logic [7:0] gain;
	logic bsw, modr, pdn, conv, nrdy, por, regs_rst;
	pm_state_type pm;
	int err_total = 0, num_checks = 0;
	row_type rows [5] = '{'{16'h0011, 16'h0011, 4'hE, 4'h1, 4'h1},
		'{16'h00FF, 16'h00FF, 4'h0, 4'hF, 4'hF}, '{16'h00A5, 16'h00A5, 4'hA, 4'h0, 4'h5},
		'{16'hF80F, 16'h000F, 4'h0, 4'h0, 4'hF}, '{16'h0000, 16'h0000, 4'hF, 4'h0, 4'h0}};
	initial forever #12.5 clk = ~clk;
	host_model u_host_model (.i_clk(clk), .o_req(req), .o_addr(addr), .o_wdata(wdata),
		.o_bit_valid(bv), .o_bit(bt));
	pwr_ctrl u_pwr_ctrl (.i_clk(clk), .i_reset(rst), .i_io_supply_ok(io_ok),
		.i_dig_ldo_ok(ldo_ok), .i_ana_supply_ok(ana_ok), .i_wr(req[0]), .i_rd(req[1]),
		.i_addr(addr), .i_wdata(wdata), .i_mode_wr(req[2]), .i_mode(wdata[3:0]),
		.i_status_rd(req[3]), .i_serial_bit_valid(bv), .i_serial_bit(bt), .i_active_ch(ch),
		.i_bridge_switch_per_channel(sw), .i_gain_code(gcode), .i_gain_stage_bypass(byp),
		.i_int_level(int_lvl), .o_rdata(rdata), .o_pin_out(pin_out), .o_pin_oe_n(oe_n),
		.o_bridge_switch(bsw), .o_gain(gain), .o_mod_reset(modr), .o_power_down(pdn),
		.o_converting(conv), .o_not_ready_bit(nrdy), .o_por_flag(por), .o_regs_reset(regs_rst),
		.o_chan0_default(), .o_cfg0_default(), .o_filter_rate_field(), .o_filter_type(),
		.o_ctrl_default(), .o_diag_default(), .o_pm_state(pm));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic rdchk(input logic [15:0] exp);
		u_host_model.xfer(4'h2, 6'h03, 16'h0000);
		chk(rdata, exp);
	endtask
	task automatic md(input logic [3:0] m, input pm_state_type s);
		u_host_model.xfer(4'h4, 6'h00, {12'h000, m});
		cyc(1);
		chk(pm, s);
	endtask
	task automatic conclude;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		err_total++;
		conclude;
	end
	initial begin
		cyc(6);
		rst = 1'b0;
		cyc(4);
		chk({oe_n, por, pm}, {4'hF, 1'b1, pm_active});
		chk(u_pwr_ctrl.o_chan0_default, 16'h8001);
		chk(u_pwr_ctrl.o_cfg0_default, 16'h0000);
		chk({u_pwr_ctrl.o_filter_type, u_pwr_ctrl.o_filter_rate_field}, 14'h0030);
		chk(u_pwr_ctrl.o_ctrl_default, 16'h0000);
		chk(u_pwr_ctrl.o_diag_default, 24'h000040);
		chk(regs_rst, 1'b0);
		rdchk(16'h0000);
		foreach (rows[i]) begin
			u_host_model.xfer(4'h1, 6'h03, rows[i].wd);
			cyc(2);
			chk(oe_n, rows[i].oe);
			chk(pin_out & rows[i].pm, rows[i].pv);
			rdchk(rows[i].rd);
		end
		for (int g = 0; g < 8; g++) begin
			gcode = 3'(g);
			byp = 1'b0;
			cyc(1);
			chk(gain, 8'h01 << g);
			byp = 1'b1;
			cyc(1);
			chk(gain, 8'h01);
		end
		for (int c = 0; c < 4; c++) begin
			ch = 4'(c);
			cyc(2);
			chk(bsw, sw[c]);
		end
		u_host_model.xfer(4'h1, 6'h03, 16'h0102);
		for (int v = 0; v < 2; v++) begin
			int_lvl = ~int_lvl;
			cyc(3);
			chk(pin_out[1], int_lvl);
		end
		md(4'h3, pm_active);
		chk(conv, 1'b1);
		u_host_model.xfer(4'h1, 6'h03, 16'h0408);
		md(4'h2, pm_standby);
		cyc(3);
		chk({pin_out[3], nrdy}, 2'h3);
		rdchk(16'h0408);
		md(4'h0, pm_active);
		md(4'h4, pm_idle);
		chk(modr, 1'b1);
		rdchk(16'h0408);
		md(4'h0, pm_active);
		chk(modr, 1'b0);
		md(4'h2, pm_standby);
		md(4'h3, pm_pdown);
		chk(pdn, 1'b1);
		chk(regs_rst, 1'b1);
		md(4'h0, pm_pdown);
		rst = 1'b1;
		cyc(1);
		rst = 1'b0;
		cyc(4);
		chk(pm, pm_active);
		u_host_model.xfer(4'h8, 6'h00, 16'h0000);
		chk(por, 1'b0);
		u_host_model.xfer(4'h1, 6'h03, 16'h0011);
		ana_ok = 1'b0;
		cyc(5);
		ana_ok = 1'b1;
		cyc(5);
		chk(por, 1'b0);
		rdchk(16'h0011);
		for (int k = 0; k < 2; k++) begin
			u_host_model.xfer(4'h1, 6'h03, 16'h0011);
			{io_ok, ldo_ok} = k ? 2'b10 : 2'b01;
			cyc(4);
			{io_ok, ldo_ok} = 2'b11;
			cyc(5);
			chk(por, 1'b1);
			rdchk(16'h0000);
			u_host_model.xfer(4'h8, 6'h00, 16'h0000);
		end
		u_host_model.xfer(4'h1, 6'h03, 16'h0011);
		u_host_model.bits(63, 1'b1);
		u_host_model.bits(1, 1'b0);
		cyc(3);
		rdchk(16'h0011);
		u_host_model.bits(64, 1'b1);
		cyc(4);
		rdchk(16'h0000);
		chk(por, 1'b1);
		conclude;
	end
endmodule // power_mode_and_output_control_tb_top
`default_nettype wire
